// ==== hdl/dsc_device.sv ====
/*
  device end: input shift register, frame decode, channel registers,
  load strobe, clear and readback. all link pins come from another domain
  and pass two flip-flops before use. the host makes sclk.
*/
// How it works
// - 24-bit shift register, msb first
// - frame: rw flag, selector, address, data
// - shifting only while frame sync low
// - wrong edge count discards the frame
// - sync rise moves word to register
// - host keeps exact clock count per frame
// - overflow bits leave on serial output
// - output changes after rising, sampled falling
// - chain needs 24 times N clocks
// - sync high latches, stops shifting
// - read frame returns register next frame
// - read enables disabled serial output briefly
// - host reads with read then nop
// - strobe low: update on sync rise
// - strobe falling after frame: update all
// - clear pin forces zero or midscale
// - clear low blocks every output update
// - clear command acts like pin
// - reset clears everything, channels powered down
// - dac code writes to powered-down channel ignored; range writes still land
// - host sets range, power, then values
// - bipolar codes offset or twos complement
`timescale 1ns/1ns
module dsc_device (
  input wire logic core_clk,
  input wire logic rst_b,
  dsc_link_if.device link,
  input wire logic coding_select,
  output logic [1:0][15:0] dac_level,
  output logic [1:0][2:0] range_sel,
  output logic [1:0] channel_powered
);
  // two-flop synchronisers, third stage only for edge finding
  logic [2:0] sclk_s;
  logic [2:0] sync_s;
  logic [2:0] load_strobe_n_s;
  logic [1:0] serial_data_in_s;
  logic [1:0] clr_s;
  logic [1:0] cod_s;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sclk_s <= 3'h7;
      sync_s <= 3'h7;
      load_strobe_n_s <= 3'h7;
      serial_data_in_s <= 2'h0;
      clr_s <= 2'h3;
      cod_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      sync_s <= {sync_s[1:0], link.sync_n};
      load_strobe_n_s <= {load_strobe_n_s[1:0], link.load_strobe_n};
      serial_data_in_s <= {serial_data_in_s[0], link.serial_data_in};
      clr_s <= {clr_s[0], link.clear_n};
      cod_s <= {cod_s[0], coding_select};
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic sync_fall;
  logic sync_rise;
  logic load_strobe_n_fall;
  logic in_frame;
  logic clr_low;
  assign sclk_fall = sclk_s[2] & ~sclk_s[1];
  assign sclk_rise = ~sclk_s[2] & sclk_s[1];
  assign sync_fall = sync_s[2] & ~sync_s[1];
  assign sync_rise = ~sync_s[2] & sync_s[1];
  assign load_strobe_n_fall = load_strobe_n_s[2] & ~load_strobe_n_s[1];
  assign in_frame = ~sync_s[1];
  assign clr_low = ~clr_s[1];

  logic [23:0] shift_reg;
  logic [4:0] edge_cnt_reg;
  logic full_seen_reg;
  logic read_pend_reg;
  logic sdo_dis_reg;
  logic clr_sel_reg;
  logic [1:0][15:0] in_reg;
  logic [15:0] read_data;

  // frame fields
  logic f_rw;
  logic [2:0] f_rsel;
  logic [2:0] f_adr;
  logic [15:0] f_data;
  logic frame_ok;
  assign f_rw = shift_reg[dsc_pkg::RW_BIT];
  assign f_rsel = shift_reg[dsc_pkg::RSEL_HI:dsc_pkg::RSEL_LO];
  assign f_adr = shift_reg[dsc_pkg::ADR_HI:dsc_pkg::ADR_LO];
  assign f_data = shift_reg[dsc_pkg::DATA_BITS-1:0];
  // whole multiples of 24 edges only, so chains latch too
  assign frame_ok = sync_rise & full_seen_reg & (edge_cnt_reg == 5'h00);

  logic do_write;
  logic do_read;
  logic clear_cmd;
  assign do_write = frame_ok & ~f_rw;
  assign do_read = frame_ok & f_rw;
  assign clear_cmd = do_write & (f_rsel == dsc_pkg::RSEL_CTRL) & (f_adr == dsc_pkg::CTL_CLEAR);

  // falling-edge count, modulo one frame
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      edge_cnt_reg <= 5'h00;
      full_seen_reg <= 1'b0;
    end else if (sync_fall) begin
      edge_cnt_reg <= 5'h00;
      full_seen_reg <= 1'b0;
    end else if (in_frame && sclk_fall) begin
      if (edge_cnt_reg == dsc_pkg::LAST_BIT) begin
        edge_cnt_reg <= 5'h00;
        full_seen_reg <= 1'b1;
      end else begin
        edge_cnt_reg <= edge_cnt_reg + 5'h01;
      end
    end
  end

  // shift register; a read frame reloads it with the selected word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      shift_reg <= 24'h000000;
    end else if (do_read) begin
      shift_reg <= {8'h00, read_data};
    end else if (in_frame && sclk_fall) begin
      shift_reg <= {shift_reg[22:0], serial_data_in_s[1]};
    end
  end

  // serial output: msb shown at sync fall, then after each rising edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      link.serial_data_out <= 1'b0;
    end else if (in_frame && (sync_fall || sclk_rise)) begin
      link.serial_data_out <= shift_reg[23];
    end
  end

  // a read keeps the output on through the following frame
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      read_pend_reg <= 1'b0;
    end else if (do_read) begin
      read_pend_reg <= 1'b1;
    end else if (sync_rise) begin
      read_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      link.serial_data_out_oe <= 1'b0;
    end else begin
      link.serial_data_out_oe <= ~sdo_dis_reg | read_pend_reg;
    end
  end

  // readback source
  always_comb begin
    read_data = 16'h0000;
    case (f_rsel)
      dsc_pkg::RSEL_DAC: read_data = (f_adr == dsc_pkg::ADR_CH_B) ? dac_level[1] : dac_level[0];
      dsc_pkg::RSEL_RANGE: read_data = {13'h0000, (f_adr == dsc_pkg::ADR_CH_B) ? range_sel[1] : range_sel[0]};
      dsc_pkg::RSEL_POWER: read_data = {14'h0000, channel_powered};
      dsc_pkg::RSEL_CTRL: begin
        read_data[dsc_pkg::CFG_SDO_DIS] = sdo_dis_reg;
        read_data[dsc_pkg::CFG_CLR_SEL] = clr_sel_reg;
      end
      default: read_data = 16'h0000;
    endcase
  end

  // control bits
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sdo_dis_reg <= 1'b0;
      clr_sel_reg <= 1'b0;
    end else if (do_write && f_rsel == dsc_pkg::RSEL_CTRL && f_adr == dsc_pkg::CTL_CONFIG) begin
      sdo_dis_reg <= f_data[dsc_pkg::CFG_SDO_DIS];
      clr_sel_reg <= f_data[dsc_pkg::CFG_CLR_SEL];
    end
  end

  // power control covers both channels in one word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      channel_powered <= 2'h0;
    end else if (do_write && f_rsel == dsc_pkg::RSEL_POWER) begin
      channel_powered <= f_data[1:0];
    end
  end

  logic [15:0] clear_code;
  logic [1:0] ch_hit;
  logic [1:0][15:0] conv_code;
  assign clear_code = clr_sel_reg ? dsc_pkg::CODE_MID : dsc_pkg::CODE_ZERO;

  // per channel: range, input and output registers
  for (genvar ch = 0; ch < dsc_pkg::NUM_CH; ch++) begin : g_ch
    assign ch_hit[ch] = (f_adr == 3'(ch)) | (f_adr == dsc_pkg::ADR_ALL);
    // twos complement becomes offset binary by flipping the msb
    assign conv_code[ch] = (cod_s[1] == 1'b0 && range_sel[ch] >= dsc_pkg::RANGE_BIPOLAR_MIN) ?
      {~f_data[15], f_data[14:0]} : f_data;

    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        range_sel[ch] <= dsc_pkg::RANGE_RESET;
      end else if (do_write && f_rsel == dsc_pkg::RSEL_RANGE && ch_hit[ch]) begin
        range_sel[ch] <= f_data[2:0];
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        in_reg[ch] <= 16'h0000;
      end else if (do_write && f_rsel == dsc_pkg::RSEL_DAC && ch_hit[ch] && channel_powered[ch]) begin
        in_reg[ch] <= conv_code[ch];
      end
    end

    // clear wins over every load path
    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        dac_level[ch] <= 16'h0000;
      end else if (clr_low || clear_cmd) begin
        dac_level[ch] <= clear_code;
      end else if (do_write && f_rsel == dsc_pkg::RSEL_DAC && ch_hit[ch] && channel_powered[ch]
                   && ~load_strobe_n_s[1]) begin
        dac_level[ch] <= conv_code[ch];
      end else if (load_strobe_n_fall && ~in_frame) begin
        dac_level[ch] <= in_reg[ch];
      end
    end
  end
endmodule // dsc_device

// ==== hdl/dsc_pkg.sv ====
/*
  shared constants of the dual dac serial control link: frame layout,
  register selectors, control functions, reset values and host timing.
  assumes both ends and the bench refer to it by dsc_pkg::name.
*/
package dsc_pkg;
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS = 16;
  localparam int NUM_CH = 2;
  // frame field positions
  localparam int RW_BIT = 23;
  localparam int RSEL_HI = 21;
  localparam int RSEL_LO = 19;
  localparam int ADR_HI = 18;
  localparam int ADR_LO = 16;
  // register selector codes
  localparam logic [2:0] RSEL_DAC = 3'h0;
  localparam logic [2:0] RSEL_RANGE = 3'h1;
  localparam logic [2:0] RSEL_POWER = 3'h2;
  localparam logic [2:0] RSEL_CTRL = 3'h3;
  // channel addresses; ADR_ALL hits every channel
  localparam logic [2:0] ADR_CH_A = 3'h0;
  localparam logic [2:0] ADR_CH_B = 3'h1;
  localparam logic [2:0] ADR_ALL = 3'h4;
  // control functions, carried in the address field of a control frame
  localparam logic [2:0] CTL_NOP = 3'h0;
  localparam logic [2:0] CTL_CONFIG = 3'h1;
  localparam logic [2:0] CTL_CLEAR = 3'h4;
  localparam int CFG_SDO_DIS = 0;
  localparam int CFG_CLR_SEL = 2;
  // range codes at or above this one are bipolar
  localparam logic [2:0] RANGE_BIPOLAR_MIN = 3'h3;
  localparam logic [2:0] RANGE_RESET = 3'h0;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [23:0] NOP_FRAME = 24'h180000;
  // host register byte offsets on the wishbone bus
  localparam logic [3:0] HREG_TX = 4'h0;
  localparam logic [3:0] HREG_STAT = 4'h4;
  localparam logic [3:0] HREG_RX = 4'h8;
  localparam logic [3:0] HREG_PIN = 4'hC;
  localparam logic [1:0] PIN_RESET = 2'h3;
  // serial clock half period made by the host
  localparam int CORE_CLK_NS = 4;
  localparam int SCLK_HALF_NS = 32;
  localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CORE_CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
  localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS - 1);
endpackage : dsc_pkg

// ==== hdl/dsc_link_if.sv ====
/*
  serial link between host and dac control: frame sync, serial clock,
  data both ways, load strobe and clear. assumes the bench ties clocks.
*/
`timescale 1ns/1ns
interface dsc_link_if;
  logic sclk;
  logic sync_n;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic load_strobe_n;
  logic clear_n;
  // resolved level of the device output, floats high when not driven
  logic sdo_wire;
  assign sdo_wire = serial_data_out_oe ? serial_data_out : 1'b1;
  modport host (output sclk, output sync_n, output serial_data_in, output load_strobe_n,
    output clear_n, input sdo_wire);
  modport device (input sclk, input sync_n, input serial_data_in, input load_strobe_n,
    input clear_n, output serial_data_out, output serial_data_out_oe);
endinterface : dsc_link_if

// ==== hdl/dsc_host.sv ====
/*
  host end: wishbone classic slave registers drive one 24-bit frame at a
  time, sclk made by a divider, device output sampled on falling edges.
  assumes the bench joins the link interface to the device.
*/
`timescale 1ns/1ns
module dsc_host (
  input wire logic core_clk,
  input wire logic rst_b,
  dsc_link_if.host link,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef enum {ST_IDLE, ST_HIGH, ST_LOW, ST_TAIL, ST_GAP} dsc_host_st_e;
  dsc_host_st_e st_reg;
  logic [23:0] tx_reg;
  logic [23:0] rx_reg;
  logic [3:0] tmr_reg;
  logic [4:0] bit_reg;
  logic [1:0] sdo_s;
  logic req;
  logic wr_tx;
  logic wr_ack;
  logic busy;
  logic tmr_done;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busy = (st_reg != ST_IDLE);
  // writes land at the edge where the master sees ack, not one earlier
  assign wr_ack = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  // a tx write while busy is dropped so a frame never tears
  assign wr_tx = wr_ack & (wb_adr_i == dsc_pkg::HREG_TX) & ~busy;
  assign tmr_done = (tmr_reg == dsc_pkg::HALF_LAST);

  // single-cycle answer, ack drops the cycle after
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      case (wb_adr_i)
        dsc_pkg::HREG_STAT: wb_dat_o <= {31'h00000000, busy};
        dsc_pkg::HREG_RX: wb_dat_o <= {8'h00, rx_reg};
        dsc_pkg::HREG_TX: wb_dat_o <= {8'h00, tx_reg};
        dsc_pkg::HREG_PIN: wb_dat_o <= {30'h00000000, link.clear_n, link.load_strobe_n};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // strobe and clear levels under software control
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {link.clear_n, link.load_strobe_n} <= dsc_pkg::PIN_RESET;
    end else if (wr_ack && wb_adr_i == dsc_pkg::HREG_PIN && wb_sel_i[0]) begin
      {link.clear_n, link.load_strobe_n} <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sdo_s <= 2'h3;
    end else begin
      sdo_s <= {sdo_s[0], link.sdo_wire};
    end
  end

  // frame sequencer: exactly 24 falling edges, then sync rises
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= ST_IDLE;
      tx_reg <= 24'h000000;
      rx_reg <= 24'h000000;
      tmr_reg <= 4'h0;
      bit_reg <= 5'h00;
      link.sclk <= 1'b1;
      link.sync_n <= 1'b1;
      link.serial_data_in <= 1'b0;
    end else begin
      tmr_reg <= tmr_done ? 4'h0 : tmr_reg + 4'h1;
      case (st_reg)
        ST_IDLE: begin
          tmr_reg <= 4'h0;
          if (wr_tx) begin
            tx_reg[7:0] <= wb_sel_i[0] ? wb_dat_i[7:0] : tx_reg[7:0];
            tx_reg[15:8] <= wb_sel_i[1] ? wb_dat_i[15:8] : tx_reg[15:8];
            tx_reg[23:16] <= wb_sel_i[2] ? wb_dat_i[23:16] : tx_reg[23:16];
            link.serial_data_in <= wb_sel_i[2] ? wb_dat_i[23] : tx_reg[23];
            link.sync_n <= 1'b0;
            bit_reg <= 5'h00;
            st_reg <= ST_HIGH;
          end
        end
        ST_HIGH: if (tmr_done) begin
          link.sclk <= 1'b0;
          rx_reg <= {rx_reg[22:0], sdo_s[1]};
          st_reg <= ST_LOW;
        end
        ST_LOW: if (tmr_done) begin
          link.sclk <= 1'b1;
          if (bit_reg == dsc_pkg::LAST_BIT) begin
            st_reg <= ST_TAIL;
          end else begin
            tx_reg <= {tx_reg[22:0], 1'b0};
            link.serial_data_in <= tx_reg[22];
            bit_reg <= bit_reg + 5'h01;
            st_reg <= ST_HIGH;
          end
        end
        ST_TAIL: if (tmr_done) begin
          link.sync_n <= 1'b1;
          st_reg <= ST_GAP;
        end
        ST_GAP: if (tmr_done) begin
          st_reg <= ST_IDLE;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // dsc_host

// ==== verification/dsc_link_chk.sv ====
/*
  checker of the serial link between host and device ends: framing,
  half periods, data stability and idle levels.
  assumes tb_top instantiates it beside the link interface.
*/
`timescale 1ns/1ns
module dsc_link_chk (
  input logic core_clk,
  input logic rst_b,
  input logic sclk,
  input logic sync_n,
  input logic serial_data_in,
  input logic serial_data_out,
  input logic serial_data_out_oe,
  input logic load_strobe_n,
  input logic clear_n
);
  logic [5:0] fall_cnt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // falling clock edges within one frame; cleared while sync is high
  always_ff @(posedge core_clk) begin
    if (!rst_b || sync_n) begin
      fall_cnt <= 6'h00;
    end else if ($fell(sclk)) begin
      fall_cnt <= fall_cnt + 6'h01;
    end
  end

  // the two halves of a link clock period
  sequence low_half;
    !sclk [*8];
  endsequence
  sequence high_half;
    sclk [*8];
  endsequence

  idle_clock_high_a: assert property (sync_n |-> sclk)
    else $error("link clock not idle high outside a frame");
  low_half_time_a: assert property ($fell(sclk) |-> low_half ##1 sclk)
    else $error("link clock low half wrong length");
  high_half_time_a: assert property ($rose(sclk) && !sync_n |-> high_half)
    else $error("link clock high half too short");
  sync_lead_a: assert property ($fell(sync_n) |-> (!sync_n && sclk) [*8])
    else $error("frame start without lead time");
  frame_count_a: assert property ($rose(sync_n) |-> fall_cnt == 6'h18)
    else $error("frame closed without 24 falling edges");
  frame_gap_a: assert property ($rose(sync_n) |-> sync_n [*8])
    else $error("frame gap too short");
  serial_data_in_stable_a: assert property (!sync_n && !sclk |-> $stable(serial_data_in))
    else $error("data in moved while clock low");
  sdo_stable_a: assert property (!sync_n && !sclk && serial_data_out_oe |-> $stable(serial_data_out))
    else $error("data out moved while clock low");
  oe_drop_a: assert property ($fell(serial_data_out_oe) |-> sync_n)
    else $error("data out released inside a frame");
  reset_idle_a: assert property ($rose(rst_b) |-> sync_n && sclk && load_strobe_n && clear_n)
    else $error("link not idle after reset");
endmodule // dsc_link_chk

// ==== verification/tb_top.sv ====
/*
  testbench: wishbone tasks drive the host end, which frames the device.
  assumes both design ends and the link interface under hdl/.
*/
`timescale 1ns/1ns
module tb_top;
  logic core_clk, rst_b, coding_select;
  logic [3:0] wb_adr, wb_sel;
  logic [31:0] wb_dat, wb_q, rd;
  logic wb_we, wb_cyc, wb_stb, wb_ack;
  logic [1:0][15:0] dac_level;
  logic [1:0][2:0] range_sel;
  logic [1:0] channel_powered;
  int miscompares;
  int checks;

  dsc_link_if link();
  dsc_host dsc_host_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link.host), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
  dsc_device dsc_device_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link.device),
    .coding_select(coding_select), .dac_level(dac_level), .range_sel(range_sel),
    .channel_powered(channel_powered));
  dsc_link_chk dsc_link_chk_inst (.core_clk(core_clk), .rst_b(rst_b), .sclk(link.sclk), .sync_n(link.sync_n),
    .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
    .serial_data_out_oe(link.serial_data_out_oe), .load_strobe_n(link.load_strobe_n), .clear_n(link.clear_n));

  task automatic give_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled, then idle one cycle
  task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    wb_adr <= a;
    wb_we <= we;
    wb_dat <= d;
    wb_sel <= 4'hF;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    rd = wb_q;
    if (n >= 40) chk({31'h0, wb_ack}, 32'h1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge core_clk);
  endtask

  // one frame, then poll busy; bounded so a stuck host cannot hang
  task automatic frame(input logic rw, input logic [2:0] s, input logic [2:0] a, input logic [15:0] d);
    int n;
    n = 0;
    wb(dsc_pkg::HREG_TX, 1'b1, {8'h00, rw, 1'b0, s, a, d});
    do begin
      wb(dsc_pkg::HREG_STAT, 1'b0, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    if (n >= 400) chk(rd, 32'h0);
  endtask

  // pin register: bit0 strobe, bit1 clear; settle past the 2ff sync
  task automatic pin(input logic [1:0] v);
    wb(dsc_pkg::HREG_PIN, 1'b1, {30'h0, v});
    repeat (8) @(posedge core_clk);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // watchdog: whole run is some 6k cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    $display("ERROR %0t: timeout", $time);
    give_verdict;
  end

  initial begin
    rst_b = 1'b0;
    coding_select = 1'b1;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    {wb_we, wb_cyc, wb_stb} = 3'h0;
    miscompares = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk(dac_level, 32'h0);
    chk({24'h0, range_sel, channel_powered}, 32'h0);
    wb(dsc_pkg::HREG_PIN, 1'b0, 32'h0);
    chk(rd, 32'h3);
    pin(2'h2);
    frame(1'b0, dsc_pkg::RSEL_DAC, dsc_pkg::ADR_CH_A, 16'h1234);
    chk(dac_level, 32'h0);
    frame(1'b0, dsc_pkg::RSEL_RANGE, dsc_pkg::ADR_ALL, 16'h0000);
    frame(1'b0, dsc_pkg::RSEL_POWER, dsc_pkg::ADR_ALL, 16'h0003);
    chk({30'h0, channel_powered}, 32'h3);
    frame(1'b0, dsc_pkg::RSEL_DAC, dsc_pkg::ADR_CH_A, 16'h1234);
    chk(dac_level, 32'h00001234);
    frame(1'b1, dsc_pkg::RSEL_DAC, dsc_pkg::ADR_CH_A, 16'hFFFF);
    frame(1'b0, dsc_pkg::RSEL_CTRL, dsc_pkg::CTL_NOP, 16'h0000);
    wb(dsc_pkg::HREG_RX, 1'b0, 32'h0);
    chk(rd, 32'h00001234);
    // strobe high while shifting, then its fall updates everything
    pin(2'h3);
    frame(1'b0, dsc_pkg::RSEL_DAC, dsc_pkg::ADR_CH_B, 16'hABCD);
    chk(dac_level, 32'h00001234);
    pin(2'h2);
    chk(dac_level, 32'hABCD1234);
    pin(2'h0);
    chk(dac_level, 32'h0);
    frame(1'b0, dsc_pkg::RSEL_DAC, dsc_pkg::ADR_CH_A, 16'h5555);
    chk(dac_level, 32'h0);
    pin(2'h2);
    chk(dac_level, 32'h0);
    // output disabled and midscale clear chosen, then clear command
    frame(1'b0, dsc_pkg::RSEL_CTRL, dsc_pkg::CTL_CONFIG, 16'h0005);
    frame(1'b0, dsc_pkg::RSEL_CTRL, dsc_pkg::CTL_CLEAR, 16'h0000);
    chk(dac_level, 32'h80008000);
    frame(1'b1, dsc_pkg::RSEL_DAC, dsc_pkg::ADR_CH_B, 16'h0000);
    frame(1'b0, dsc_pkg::RSEL_CTRL, dsc_pkg::CTL_NOP, 16'h0000);
    wb(dsc_pkg::HREG_RX, 1'b0, 32'h0);
    chk(rd, 32'h00008000);
    // bipolar range on channel a, both code formats
    frame(1'b0, dsc_pkg::RSEL_RANGE, dsc_pkg::ADR_CH_A, 16'h0003);
    // channel b keeps range 0, both channels stay powered
    chk({24'h0, range_sel, channel_powered}, 32'h0000000F);
    coding_select <= 1'b0;
    frame(1'b0, dsc_pkg::RSEL_DAC, dsc_pkg::ADR_CH_A, 16'h0001);
    chk(dac_level, 32'h80008001);
    coding_select <= 1'b1;
    frame(1'b0, dsc_pkg::RSEL_DAC, dsc_pkg::ADR_CH_A, 16'h0001);
    chk(dac_level, 32'h80000001);
    give_verdict;
  end
endmodule // tb_top
